//--- sim/output_gate_and_lock_status_test.sv
// Testbench: register, enable, clock-stop and sticky flag checks
`timescale 1ns/1ps
`default_nettype none

module output_gate_and_lock_status_test;
  import outgate_pkg::*;
  // ----------------------------------------
  // Signals, notes and counters
  // ----------------------------------------
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  reg_req_s    i_req = '0;
  logic        i_req_valid = 1'b0;
  logic [3:0]  i_src_clk = 4'h0;
  logic [1:0]  i_lock = 2'h3;
  logic [7:0]  o_rdata;
  logic [3:0]  o_clk_out;
  logic [3:0]  o_clk_oe;
  logic [7:0]  o_diff_oe;
  logic        note_go = 1'b0;
  logic        due = 1'b0;
  logic        src_run = 1'b0;
  logic [3:0]  src_level = 4'h0;
  logic [2:0]  div = 3'h0;
  logic [7:0]  rnd = 8'h1C;
  logic [9:0]  notes[$];
  logic [9:0]  note;
  logic [7:0]  seen;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  // Each entry: stop byte, held source level, expected outputs
  logic [15:0] stop_tab [6] = '{16'h00AA, 16'h5555, 16'hAAF0, 16'hFF0F, 16'hEE5A, 16'h0099};

  always #4 i_clk = ~i_clk;

  output_gate_and_lock_status i_dut (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_req       (i_req),
    .i_req_valid (i_req_valid),
    .i_src_clk   (i_src_clk),
    .i_lock      (i_lock),
    .o_rdata     (o_rdata),
    .o_clk_out   (o_clk_out),
    .o_clk_oe    (o_clk_oe),
    .o_diff_oe   (o_diff_oe)
  );

  // Source clocks toggle every 4 cycles, far below the synchroniser limit
  always @(negedge i_clk) begin
    div <= div + 3'h1;
    i_src_clk <= src_run ? ({4{div[2]}} ^ 4'h5) : src_level;
  end

  // ----------------------------------------
  // Monitor: one note is due a cycle after it was posted
  // ----------------------------------------
  always @(posedge i_clk) due <= note_go;
  always @(negedge i_clk) begin
    if (due === 1'b1) begin
      note = notes.pop_front();
      case (note[9:8])
        2'h0: seen = o_rdata;
        2'h1: seen = {4'h0, o_clk_oe};
        2'h2: seen = o_diff_oe;
        default: seen = {4'h0, o_clk_out};
      endcase
      check(seen, note[7:0]);
    end
  end

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask : check

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Kind 0 is a bus access; other kinds only post an output probe
  task automatic op(input logic [1:0] k, input logic w, input logic [7:0] a, d, e);
    i_req = '{wr: w, addr: a, wdata: d};
    i_req_valid = (k == 2'h0);
    note_go = !w;
    if (!w) notes.push_back({k, e});
    @(negedge i_clk);
  endtask : op

  task automatic wr(input logic [7:0] a, d);
    op(2'h0, 1'h1, a, d, 8'h00);
  endtask : wr

  task automatic rd(input logic [7:0] a, e);
    op(2'h0, 1'h0, a, 8'h00, e);
  endtask : rd

  task automatic idle(input int n);
    i_req_valid = 1'b0;
    note_go = 1'b0;
    repeat (n) @(negedge i_clk);
  endtask : idle

  task automatic do_reset();
    i_reset = 1'b1;
    repeat (12) @(negedge i_clk);
    i_reset = 1'b0;
  endtask : do_reset

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    rd(STATUS_ADDR, 8'h03);
    rd(SE_EN_ADDR, SE_EN_RST);
    rd(STOP_ADDR, STOP_RST);
    rd(CLEAR_ADDR, CLEAR_RST);
    rd(DIFF_EN_ADDR, DIFF_EN_RST);
    rd(8'h00, 8'h00);
    op(2'h1, 1'h0, 8'h00, 8'h00, 8'h00);
    idle(2);
    $display("test reset done");
    // A loss while the clear is held must not set the flag later
    wr(CLEAR_ADDR, 8'h03);
    idle(2);
    rd(STATUS_ADDR, 8'h00);
    i_lock = 2'h0;
    idle(8);
    rd(STATUS_ADDR, 8'h00);
    i_lock = 2'h3;
    wr(CLEAR_ADDR, 8'h00);
    idle(8);
    rd(STATUS_ADDR, 8'h00);
    i_lock = 2'h2;
    idle(8);
    rd(STATUS_ADDR, 8'h01);
    i_lock = 2'h0;
    idle(8);
    rd(STATUS_ADDR, 8'h03);
    i_lock = 2'h3;
    wr(STATUS_ADDR, 8'h00);
    wr(CLEAR_ADDR, 8'h01);
    idle(2);
    rd(STATUS_ADDR, 8'h02);
    wr(CLEAR_ADDR, 8'h00);
    $display("test flags done");
    for (int n = 0; n < 6; n++) begin
      rnd = lfsr(rnd);
      wr(SE_EN_ADDR, rnd);
      wr(DIFF_EN_ADDR, ~rnd);
      rd(SE_EN_ADDR, rnd);
      rd(DIFF_EN_ADDR, ~rnd);
      op(2'h1, 1'h0, 8'h00, 8'h00, {4'h0, rnd[3:0]});
      op(2'h2, 1'h0, 8'h00, 8'h00, ~rnd);
    end
    $display("test enables done");
    foreach (stop_tab[i]) begin
      wr(STOP_ADDR, stop_tab[i][15:8]);
      src_run = 1'b1;
      idle(24);
      src_run = 1'b0;
      src_level = stop_tab[i][7:4];
      idle(10);
      rd(STOP_ADDR, stop_tab[i][15:8]);
      op(2'h3, 1'h0, 8'h00, 8'h00, {4'h0, stop_tab[i][3:0]});
    end
    $display("test clock stop done");
    idle(1);
    do_reset();
    rd(STATUS_ADDR, 8'h03);
    rd(SE_EN_ADDR, 8'h00);
    op(2'h1, 1'h0, 8'h00, 8'h00, 8'h00);
    idle(4);
    $display("test second reset done");
    report_and_stop();
  end

  // Hang guard, nearly nine times the expected run
  initial begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : output_gate_and_lock_status_test

`default_nettype wire

//--- src/outgate_pkg.sv
// Package: register map, field layout and types for the output gate and lock status bank
package outgate_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the configuration port
  // ----------------------------------------------------------------
  localparam logic [7:0] DIFF_EN_ADDR  = 8'hB0;
  localparam logic [7:0] SE_EN_ADDR    = 8'hB1;
  localparam logic [7:0] STOP_ADDR     = 8'hB8;
  localparam logic [7:0] STATUS_ADDR   = 8'hB9;
  localparam logic [7:0] CLEAR_ADDR    = 8'hBA;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] DIFF_EN_RST   = 8'h00;
  localparam logic [7:0] SE_EN_RST     = 8'h00;
  localparam logic [7:0] STOP_RST      = 8'h00;
  localparam logic [1:0] STICKY_RST    = 2'h3;
  localparam logic [7:0] CLEAR_RST     = 8'h00;
  localparam int         SE_OUTS       = 4;
  localparam int         DIFF_OUTS     = 8;
  localparam int         SYNTHS        = 2;
  localparam int         HALT_W        = 2;

  // Halt selections of one clock-stop field
  localparam logic [1:0] HALT_LOW      = 2'h2;
  localparam logic [1:0] HALT_HIGH     = 2'h3;

  // Register access request from the configuration port
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : outgate_pkg

//--- src/output_gate_and_lock_status.sv
// Module: output enables, glitch-free clock stop and sticky lock-loss flags
// --------------------------------------------------------------------------
// Overview of operation
// [RULE_01] Bit n of the single-ended enable register enables single-ended output n.
// [RULE_02] A zero enable bit puts its single-ended output driver into high impedance.
// [RULE_03] The stop register holds four two-bit fields, bits 1:0 to 7:6 for clocks zero to three.
// [RULE_04] Field values 00 and 01 leave the clock running continuously.
// [RULE_05] Field value 10 stops the clock at its falling edge and holds it low.
// [RULE_06] Field value 11 stops the clock at its rising edge and holds it high.
// [RULE_07] Status bit 0 is a sticky flag set on synthesizer zero lock loss, held until cleared.
// [RULE_08] Status bit 1 and clear bit 1 do the same for synthesizer one.
// [RULE_09] Both sticky flags are set on reset regardless of the lock state.
// [RULE_10] While clear bit 0 is high the synthesizer zero flag is cleared.
// [RULE_11] Software returns each clear bit to zero after clearing its flag.
// [RULE_12] Software treats a flag seen high after clearing as a genuine lock loss.
// [RULE_13] Each differential enable bit enables its output when one and tristates it when zero.
// [RULE_14] The clear is a level; a lock loss sets the flag again only once the clear returns low.
// [RULE_15] A stop or restart takes effect only at the selected edge, so no runt pulse appears.
// --------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module output_gate_and_lock_status (
  input  wire  logic                             i_clk,
  input  wire  logic                             i_reset,
  input  wire  outgate_pkg::reg_req_s            i_req,
  input  wire  logic                             i_req_valid,
  input  wire  logic [outgate_pkg::SE_OUTS-1:0]  i_src_clk,
  input  wire  logic [outgate_pkg::SYNTHS-1:0]   i_lock,
  output logic [7:0]                             o_rdata,
  output logic [outgate_pkg::SE_OUTS-1:0]        o_clk_out,
  output logic [outgate_pkg::SE_OUTS-1:0]        o_clk_oe,
  output logic [outgate_pkg::DIFF_OUTS-1:0]      o_diff_oe
);
  import outgate_pkg::*;

  // --------------------------------------------------------------
  // Registers and synchronisers
  // --------------------------------------------------------------
  logic [7:0]          se_en_r;
  logic [7:0]          stop_r;
  logic [7:0]          clear_r;
  logic [7:0]          diff_en_r;
  logic [SYNTHS-1:0]   sticky_r;
  logic [SYNTHS-1:0]   lock_m_r;
  logic [SYNTHS-1:0]   lock_s_r;
  logic [SYNTHS-1:0]   lock_d_r;
  logic [SE_OUTS-1:0]  src_m_r;
  logic [SE_OUTS-1:0]  src_s_r;
  logic [SE_OUTS-1:0]  src_d_r;
  logic [SE_OUTS-1:0]  halted_r;
  logic [SE_OUTS-1:0]  halted_nxt;
  logic [SE_OUTS-1:0]  out_nxt;
  logic [SYNTHS-1:0]   sticky_nxt;
  logic [SYNTHS-1:0]   lock_fall;
  logic [7:0]          rdata_nxt;
  logic                wr_se;
  logic                wr_stop;
  logic                wr_clear;
  logic                wr_diff;

  // Address decode of the configuration port
  assign wr_se    = i_req_valid && i_req.wr && (i_req.addr == SE_EN_ADDR);
  assign wr_stop  = i_req_valid && i_req.wr && (i_req.addr == STOP_ADDR);
  assign wr_clear = i_req_valid && i_req.wr && (i_req.addr == CLEAR_ADDR);
  assign wr_diff  = i_req_valid && i_req.wr && (i_req.addr == DIFF_EN_ADDR);

  // Read mux; unmapped addresses read zero, reserved enable bits read back as written
  assign rdata_nxt = (i_req.addr == SE_EN_ADDR)   ? se_en_r   :
                     (i_req.addr == STOP_ADDR)    ? stop_r    :
                     (i_req.addr == STATUS_ADDR)  ? {6'h00, sticky_r} :
                     (i_req.addr == CLEAR_ADDR)   ? clear_r   :
                     (i_req.addr == DIFF_EN_ADDR) ? diff_en_r : 8'h00;

  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      se_en_r   <= SE_EN_RST;
      stop_r    <= STOP_RST;
      clear_r   <= CLEAR_RST;
      diff_en_r <= DIFF_EN_RST;
      o_rdata   <= 8'h00;
    end else begin
      if (wr_se)    se_en_r   <= i_req.wdata;
      if (wr_stop)  stop_r    <= i_req.wdata;
      if (wr_clear) clear_r   <= i_req.wdata;
      if (wr_diff)  diff_en_r <= i_req.wdata;
      if (i_req_valid && !i_req.wr) o_rdata <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------
  // Lock-loss detection
  // --------------------------------------------------------------
  // Lock and source clocks arrive from other domains: two flops first
  always_ff @(posedge i_clk) begin
    lock_m_r <= i_lock;
    lock_s_r <= lock_m_r;
    lock_d_r <= lock_s_r;
    src_m_r  <= i_src_clk;
    src_s_r  <= src_m_r;
    src_d_r  <= src_s_r;
  end

  // A loss is the falling edge of the synchronised lock level
  assign lock_fall = lock_d_r & ~lock_s_r;

  // Clear held high dominates; loss events re-arm once it drops
  assign sticky_nxt = (sticky_r | lock_fall) & ~clear_r[SYNTHS-1:0];  // RULE_07 RULE_08 RULE_10 RULE_14

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sticky_r <= STICKY_RST;  // RULE_09
    end else begin
      sticky_r <= sticky_nxt;
    end
  end

  // --------------------------------------------------------------
  // Clock stop and output gating, one slice per output
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < SE_OUTS; g++) begin : g_out
      logic [HALT_W-1:0] sel;
      logic              halt_req;
      logic              at_edge;
      assign sel      = stop_r[g*HALT_W +: HALT_W];  // RULE_03
      assign halt_req = sel[1];  // RULE_04
      // Falling edge for hold-low, rising edge for hold-high
      assign at_edge  = sel[0] ? (src_s_r[g] & ~src_d_r[g]) : (~src_s_r[g] & src_d_r[g]);
      // Move toward the request only on the selected edge, never between edges
      assign halted_nxt[g] = (halt_req != halted_r[g] && at_edge) ?
                             halt_req : halted_r[g];  // RULE_15
      // Halted level equals the selected edge's landing level, so no runt is made
      assign out_nxt[g] = halted_r[g] ? sel[0] : src_s_r[g];  // RULE_05 RULE_06
    end
  endgenerate

  // Halt state of all slices in one process, so no vector has several writers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      halted_r <= '0;
    end else begin
      halted_r <= halted_nxt;
    end
  end

  // Output flops
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_clk_out <= '0;
      o_clk_oe  <= '0;
      o_diff_oe <= '0;
    end else begin
      o_clk_out <= out_nxt;
      o_clk_oe  <= se_en_r[SE_OUTS-1:0];  // RULE_01 RULE_02
      o_diff_oe <= diff_en_r;  // RULE_13
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  a_sticky_reset: assert property (@(posedge i_clk)  // RULE_09
    $fell(i_reset) |-> sticky_r == STICKY_RST)
    else $error("sticky flags not set after reset");

  a_clear_dominates: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_10
    clear_r[0] |=> !sticky_r[0])
    else $error("flag 0 not cleared while clear high");

  a_clear_one: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_08
    clear_r[1] |=> !sticky_r[1])
    else $error("flag 1 not cleared while clear high");

  a_loss_sets: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_07
    (lock_fall[0] && !clear_r[0]) |=> sticky_r[0])
    else $error("lock loss did not set flag 0");

  a_flag_holds: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_14
    (sticky_r[0] && !clear_r[0]) |=> sticky_r[0])
    else $error("sticky flag 0 dropped without clear");

  a_oe_follows: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_01
    wr_se ##2 1'b1 |-> o_clk_oe == $past(i_req.wdata[SE_OUTS-1:0], 2))
    else $error("single-ended enable not applied");

  a_diff_follows: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_13
    wr_diff ##2 1'b1 |-> o_diff_oe == $past(i_req.wdata, 2))
    else $error("differential enable not applied");

  a_halt_low: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_05
    (halted_r[0] && stop_r[1:0] == HALT_LOW) |=> !o_clk_out[0])
    else $error("halted clock 0 not low");

  a_halt_high: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_06
    (halted_r[0] && stop_r[1:0] == HALT_HIGH) |=> o_clk_out[0])
    else $error("halted clock 0 not high");

  a_run_mode: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_04
    (!stop_r[1] && !halted_r[0]) |=> o_clk_out[0] == $past(src_s_r[0]))
    else $error("running clock 0 not passed through");

  // Halt entry on clock 0: the selected edge arrives while a halt is pending
  sequence s_halt_pending0;
    stop_r[1] && !halted_r[0] && g_out[0].at_edge;
  endsequence

  // The landing level shows first, then the held level, with no pulse between
  sequence s_held_level0;
    (o_clk_out[0] == $past(stop_r[0])) ##1 (o_clk_out[0] == $past(stop_r[0]));
  endsequence

  // Restart on clock 0: the selected edge arrives while halted and running is asked
  sequence s_restart_pending0;
    !stop_r[1] && halted_r[0] && g_out[0].at_edge;
  endsequence

  a_halt_entry: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_15
    s_halt_pending0 |=> s_held_level0)
    else $error("clock 0 halt not clean");

  a_restart_clean: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_15
    s_restart_pending0 |=> !halted_r[0] ##1 (o_clk_out[0] == $past(src_s_r[0])))
    else $error("clock 0 restart not clean");

  a_loss_sets_one: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_08
    (lock_fall[1] && !clear_r[1]) |=> sticky_r[1])
    else $error("lock loss did not set flag 1");

  a_oe_tristate: assert property (@(posedge i_clk) disable iff (i_reset)  // RULE_02
    (wr_se && !i_req.wdata[0]) ##2 1'b1 |-> !o_clk_oe[0])
    else $error("single-ended output 0 not tristated");

endmodule : output_gate_and_lock_status

`default_nettype wire
